// file: common/pdmm_consts.svh
// Purpose: constants of the program/data memory mapper
// Assumes: 8-bit data space, 12-bit program counter, 13-bit program memory address
// Notes:   offsets are data-space byte addresses
`ifndef PDMM_CONSTS_SVH
`define PDMM_CONSTS_SVH

`define PDMM_ADDR_WINDOW_BASE  8'hC9
`define PDMM_ADDR_PAGE_SELECT  8'hCA
`define PDMM_ADDR_BANK_SELECT  8'hCB
`define PDMM_ADDR_INT_OPTION   8'hC8
`define PDMM_ADDR_SERIAL_DIS   8'hDC
`define PDMM_ADDR_ACCUM        8'hFF
`define PDMM_BANK_TOP          8'h3F
`define PDMM_WIN_LO            8'h40
`define PDMM_WIN_HI            8'h7F
`define PDMM_PTR_LO            8'h80
`define PDMM_PTR_HI            8'h83
`define PDMM_RAM_LO            8'h84
`define PDMM_RAM_HI            8'hBF
`define PDMM_PDATA_LO          8'hC0
`define PDMM_PDATA_HI          8'hC3
`define PDMM_PDIR_LO           8'hC4
`define PDMM_PDIR_HI           8'hC7
`define PDMM_POPT_LO           8'hCC
`define PDMM_POPT_HI           8'hCF
`define PDMM_PC_STATIC_BIT     11
`define PDMM_STATIC_PAGE       2'h1
`define PDMM_BANK1_BIT         3
`define PDMM_BANK2_BIT         4
`define PDMM_STACK_DEPTH       6

`endif

// file: common/pdmm_pkg.sv
// Purpose: types of the program/data memory mapper
// Assumes: nothing beyond the constants header
// Notes:   region codes drive chip-select style outputs
package pdmm_pkg;
	typedef enum logic [3:0] {
		PDMM_REG_NONE,
		PDMM_REG_RAM_BANK0,
		PDMM_REG_RAM_BANK1,
		PDMM_REG_RAM_BANK2,
		PDMM_REG_ROM_WINDOW,
		PDMM_REG_POINTER,
		PDMM_REG_RAM,
		PDMM_REG_PORT_DATA,
		PDMM_REG_PORT_DIR,
		PDMM_REG_PORT_OPT,
		PDMM_REG_WRITE_ONLY,
		PDMM_REG_ACCUM,
		PDMM_REG_PERIPH
	} pdmm_region_t;

	typedef enum logic [1:0] {
		PDMM_STK_IDLE,
		PDMM_STK_PUSH,
		PDMM_STK_POP
	} pdmm_stack_op_t;
endpackage

// file: common/pdmm_stack_if.sv
// Purpose: carrier between the mapper and its return-address stack
// Assumes: single core clock
// Notes:   one operation per cycle
`timescale 1ns/1ns
interface pdmm_stack_if;
	pdmm_pkg::pdmm_stack_op_t op;
	logic [11:0]              push_addr;
	logic [11:0]              top_addr;
	logic [2:0]               level;
	modport owner (output op, output push_addr, input top_addr, input level);
	modport stack (input op, input push_addr, output top_addr, output level);
endinterface

// file: hdl/pdmm_return_stack.sv
// Purpose: six-level stack of 12-bit return addresses
// Assumes: core never pushes when full nor pops when empty
// Notes:   top comes out of a register; overflow drops the push
`timescale 1ns/1ns
`include "pdmm_consts.svh"
module pdmm_return_stack #(
	parameter int DEPTH = `PDMM_STACK_DEPTH
) (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	pdmm_stack_if.stack     stk
);
	typedef struct packed {
		logic [DEPTH-1:0][11:0] entry;
		logic [2:0]             level;
		logic [11:0]            top;
	} pdmm_stack_state_t;

	pdmm_stack_state_t st;
	pdmm_stack_state_t next_st;

	always_comb begin
		next_st = st;
		unique case (stk.op)
			pdmm_pkg::PDMM_STK_PUSH: begin
				if (st.level < 3'(DEPTH)) begin
					next_st.entry[st.level] = stk.push_addr;
					next_st.level = st.level + 3'h1;
					next_st.top = stk.push_addr;
				end
			end
			pdmm_pkg::PDMM_STK_POP: begin
				if (st.level != 3'h0) begin
					next_st.level = st.level - 3'h1;
					next_st.top = (st.level > 3'h1) ? st.entry[st.level - 3'h2] : 12'h000;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign stk.top_addr = st.top;
	assign stk.level    = st.level;
endmodule

// file: hdl/pdmm_mapper.sv
// Purpose: program paging, data-space ROM window and data-space decode
// Assumes: core addresses are synchronous to core_clk; one access per cycle
// Notes:   page, window and bank registers are not reset (left as in silicon)
`timescale 1ns/1ns
`include "pdmm_consts.svh"
module pdmm_mapper (
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	input  wire logic [11:0]           pc_addr,
	input  wire logic [7:0]            data_addr,
	input  wire logic                  data_wr,
	input  wire logic                  data_rd,
	input  wire logic [7:0]            data_wdata,
	input  wire logic                  ext_read_req,
	input  wire logic [12:0]           ext_read_addr,
	input  wire logic                  readout_protect,
	input  wire logic                  call_push,
	input  wire logic                  ret_pop,
	input  wire logic [11:0]           return_addr,
	output logic [12:0]                prog_fetch_addr,
	output logic [12:0]                rom_window_addr,
	output logic                       rom_window_rd,
	output logic [12:0]                ext_mem_addr,
	output logic                       ext_mem_rd,
	output logic                       ext_read_blocked,
	output pdmm_pkg::pdmm_region_t     data_region,
	output logic [1:0]                 ram_bank_sel,
	output logic                       write_only_hit,
	output logic [11:0]                stack_top,
	output logic [2:0]                 stack_level
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [1:0]              page_select_bits;
		logic [6:0]              window_base_bits;
		logic [1:0]              bank_bits;
		logic [12:0]             fetch_addr;
		logic [12:0]             win_addr;
		logic                    win_rd;
		logic [12:0]             ext_addr;
		logic                    ext_rd;
		logic                    ext_blocked;
		pdmm_pkg::pdmm_region_t  region;
		logic [1:0]              bank_out;
		logic                    wo_hit;
	} pdmm_state_t;

	pdmm_state_t st;
	pdmm_state_t next_st;
	pdmm_stack_if stk ();

	pdmm_return_stack #(.DEPTH(`PDMM_STACK_DEPTH)) u_stack (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.stk      (stk)
	);

	// ----------------------------------------
	// return stack control
	// ----------------------------------------
	// stack traffic never touches the page register, only the stack
	always_comb begin
		stk.push_addr = return_addr;
		if (call_push) begin
			stk.op = pdmm_pkg::PDMM_STK_PUSH;
		end else if (ret_pop) begin
			stk.op = pdmm_pkg::PDMM_STK_POP;
		end else begin
			stk.op = pdmm_pkg::PDMM_STK_IDLE;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [1:0] page;
		logic       in_bank;
		logic       in_window;
		logic       in_pointer;
		logic       in_ram;
		logic       in_port_data;
		logic       in_port_dir;
		logic       in_map_regs;
		logic       in_port_opt;
		logic       in_write_only;

		page          = 2'h0;
		in_bank       = data_addr <= `PDMM_BANK_TOP;
		in_window     = data_addr >= `PDMM_WIN_LO && data_addr <= `PDMM_WIN_HI;
		in_pointer    = data_addr >= `PDMM_PTR_LO && data_addr <= `PDMM_PTR_HI;
		in_ram        = data_addr >= `PDMM_RAM_LO && data_addr <= `PDMM_RAM_HI;
		in_port_data  = data_addr >= `PDMM_PDATA_LO && data_addr <= `PDMM_PDATA_HI;
		in_port_dir   = data_addr >= `PDMM_PDIR_LO && data_addr <= `PDMM_PDIR_HI;
		in_map_regs   = data_addr >= `PDMM_ADDR_INT_OPTION && data_addr <= `PDMM_ADDR_BANK_SELECT;
		in_port_opt   = data_addr >= `PDMM_POPT_LO && data_addr <= `PDMM_POPT_HI;
		in_write_only = in_map_regs || data_addr == `PDMM_ADDR_SERIAL_DIS;
		next_st       = st;


		// ------------------------------------
		// write-only registers: reads fall through untouched
		// ------------------------------------
		if (data_wr && data_addr == `PDMM_ADDR_PAGE_SELECT) begin
			next_st.page_select_bits = data_wdata[1:0];
		end
		if (data_wr && data_addr == `PDMM_ADDR_WINDOW_BASE) begin
			next_st.window_base_bits = data_wdata[6:0];
		end
		if (data_wr && data_addr == `PDMM_ADDR_BANK_SELECT) begin
			next_st.bank_bits = {data_wdata[`PDMM_BANK2_BIT], data_wdata[`PDMM_BANK1_BIT]};
		end

		// ------------------------------------
		// program paging
		// ------------------------------------
		if (pc_addr[`PDMM_PC_STATIC_BIT]) begin
			page = `PDMM_STATIC_PAGE;
		end else begin
			page = st.page_select_bits;
		end
		next_st.fetch_addr = {page, pc_addr[10:0]};

		// ------------------------------------
		// data-space decode
		// ------------------------------------
		// ranges are disjoint; order only sets the unlisted fall-through
		if (in_bank) begin
			if (st.bank_bits[0]) begin
				next_st.region = pdmm_pkg::PDMM_REG_RAM_BANK1;
			end else if (st.bank_bits[1]) begin
				next_st.region = pdmm_pkg::PDMM_REG_RAM_BANK2;
			end else begin
				next_st.region = pdmm_pkg::PDMM_REG_RAM_BANK0;
			end
		end else if (in_window) begin
			next_st.region = pdmm_pkg::PDMM_REG_ROM_WINDOW;
		end else if (in_pointer) begin
			next_st.region = pdmm_pkg::PDMM_REG_POINTER;
		end else if (in_ram) begin
			next_st.region = pdmm_pkg::PDMM_REG_RAM;
		end else if (in_port_data) begin
			next_st.region = pdmm_pkg::PDMM_REG_PORT_DATA;
		end else if (in_port_dir) begin
			next_st.region = pdmm_pkg::PDMM_REG_PORT_DIR;
		end else if (in_map_regs) begin
			next_st.region = pdmm_pkg::PDMM_REG_WRITE_ONLY;
		end else if (in_port_opt) begin
			next_st.region = pdmm_pkg::PDMM_REG_PORT_OPT;
		end else if (data_addr == `PDMM_ADDR_SERIAL_DIS) begin
			next_st.region = pdmm_pkg::PDMM_REG_WRITE_ONLY;
		end else if (data_addr == `PDMM_ADDR_ACCUM) begin
			next_st.region = pdmm_pkg::PDMM_REG_ACCUM;
		end else begin
			next_st.region = pdmm_pkg::PDMM_REG_PERIPH;
		end
		next_st.bank_out = st.bank_bits;
		next_st.wo_hit = (data_rd || data_wr) && in_write_only;

		// ------------------------------------
		// rom window: base above six low address bits, read-only
		// ------------------------------------
		next_st.win_addr = {st.window_base_bits, data_addr[5:0]};
		next_st.win_rd = data_rd && in_window;

		// ------------------------------------
		// external readout, gated by protection option
		// ------------------------------------
		next_st.ext_addr = ext_read_addr;
		next_st.ext_rd = ext_read_req && !readout_protect;
		next_st.ext_blocked = ext_read_req && readout_protect;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// mapping registers deliberately outside reset: software must load them
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			// page, window and bank bits keep whatever they held
			st.fetch_addr  <= 13'h0000;
			st.win_addr    <= 13'h0000;
			st.win_rd      <= 1'b0;
			st.ext_addr    <= 13'h0000;
			st.ext_rd      <= 1'b0;
			st.ext_blocked <= 1'b0;
			st.region      <= pdmm_pkg::PDMM_REG_NONE;
			st.bank_out    <= 2'h0;
			st.wo_hit      <= 1'b0;
		end else begin
			st.page_select_bits <= next_st.page_select_bits;
			st.window_base_bits <= next_st.window_base_bits;
			st.bank_bits        <= next_st.bank_bits;
			st.fetch_addr       <= next_st.fetch_addr;
			st.win_addr         <= next_st.win_addr;
			st.win_rd           <= next_st.win_rd;
			st.ext_addr         <= next_st.ext_addr;
			st.ext_rd           <= next_st.ext_rd;
			st.ext_blocked      <= next_st.ext_blocked;
			st.region           <= next_st.region;
			st.bank_out         <= next_st.bank_out;
			st.wo_hit           <= next_st.wo_hit;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prog_fetch_addr  = st.fetch_addr;
	assign rom_window_addr  = st.win_addr;
	assign rom_window_rd    = st.win_rd;
	assign ext_mem_addr     = st.ext_addr;
	assign ext_mem_rd       = st.ext_rd;
	assign ext_read_blocked = st.ext_blocked;
	assign data_region      = st.region;
	assign ram_bank_sel     = st.bank_out;
	assign write_only_hit   = st.wo_hit;
	assign stack_top        = stk.top_addr;
	assign stack_level      = stk.level;
endmodule

// file: tb/pdmm_mapper_checker.sv
// Purpose: port-level checks of the memory mapper
// Assumes: one core clock, asynchronous active-low reset
// Notes:   page, window and bank are judged only after a write is seen
`timescale 1ns/1ns
module pdmm_mapper_checker (
	input wire logic                   core_clk,
	input wire logic                   reset_n,
	input wire logic [11:0]            pc_addr,
	input wire logic [7:0]             data_addr,
	input wire logic                   data_wr,
	input wire logic                   data_rd,
	input wire logic [7:0]             data_wdata,
	input wire logic                   ext_read_req,
	input wire logic [12:0]            ext_read_addr,
	input wire logic                   readout_protect,
	input wire logic                   call_push,
	input wire logic                   ret_pop,
	input wire logic [11:0]            return_addr,
	input wire logic [12:0]            prog_fetch_addr,
	input wire logic [12:0]            rom_window_addr,
	input wire logic                   rom_window_rd,
	input wire logic [12:0]            ext_mem_addr,
	input wire logic                   ext_mem_rd,
	input wire logic                   ext_read_blocked,
	input wire pdmm_pkg::pdmm_region_t data_region,
	input wire logic [1:0]             ram_bank_sel,
	input wire logic                   write_only_hit,
	input wire logic [11:0]            stack_top,
	input wire logic [2:0]             stack_level
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire        in_win = data_addr[7:6] == 2'h1;
	wire        wo_loc = data_addr[7:2] == 6'h32 || data_addr == 8'hdc;
	logic [6:0] win_img;
	logic [1:0] page_img;
	logic [1:0] bank_img;
	logic [2:0] seen;
	// ---------------------------------------------------------------
	// images of the window, page and bank write-only registers; reads must never touch them
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			seen <= 3'h0;
		end else if (data_wr && data_addr == 8'hc9) begin
			win_img <= data_wdata[6:0];
			seen[0] <= 1'b1;
		end else if (data_wr && data_addr == 8'hca) begin
			page_img <= data_wdata[1:0];
			seen[1] <= 1'b1;
		end else if (data_wr && data_addr == 8'hcb) begin
			bank_img <= {data_wdata[4], data_wdata[3]};
			seen[2] <= 1'b1;
		end
	end
	AST_WIN_ADDR: assert property (data_rd && in_win && seen[0] |=> rom_window_rd &&
		rom_window_addr == {$past(win_img), $past(data_addr[5:0])}) else $error("window address wrong");
	AST_WIN_ONLY: assert property (data_rd && !in_win |=> !rom_window_rd)
		else $error("window read outside window");
	AST_PAGE: assert property (!pc_addr[11] && seen[1] |=>
		prog_fetch_addr == {$past(page_img), $past(pc_addr[10:0])}) else $error("paged fetch wrong");
	AST_STATIC: assert property (pc_addr[11] |=> prog_fetch_addr == {2'h1, $past(pc_addr[10:0])})
		else $error("static fetch wrong");
	AST_BANK: assert property (seen[2] |=> ram_bank_sel == $past(bank_img))
		else $error("bank select wrong");
	AST_PROTECT: assert property (ext_read_req && readout_protect |=> ext_read_blocked && !ext_mem_rd)
		else $error("protected readout passed");
	AST_READOUT: assert property (ext_read_req && !readout_protect |=> ext_mem_rd &&
		ext_mem_addr == $past(ext_read_addr)) else $error("readout missing");
	AST_WO_HIT: assert property ((data_rd || data_wr) && wo_loc |=> write_only_hit)
		else $error("write-only location missed");
	AST_RAM: assert property (data_addr[7:6] == 2'h2 && data_addr[5:2] != 4'h0 |=>
		data_region == pdmm_pkg::PDMM_REG_RAM) else $error("ram decode wrong");
	AST_PUSH: assert property (call_push && stack_level < 3'h6 |=> stack_level == $past(stack_level) + 3'h1
		&& stack_top == $past(return_addr)) else $error("push lost");
	COV_WIN: cover property (data_rd && in_win && seen[0]);
	COV_STATIC: cover property (pc_addr[11]);
	COV_PROT: cover property (ext_read_req && readout_protect);
endmodule
bind pdmm_mapper pdmm_mapper_checker chk (.*);

// file: tb/pdmm_core_model.sv
// Purpose: processor core issuing data accesses and stack operations
// Assumes: driven at the falling edge, one access per call
// Notes:   write data is inverted after each write so stale data shows
`timescale 1ns/1ns
module pdmm_core_model (
	input wire logic core_clk,
	output logic     [11:0] pc_addr,
	output logic     [7:0]  data_addr,
	output logic            data_wr,
	output logic            data_rd,
	output logic     [7:0]  data_wdata,
	output logic            ext_read_req,
	output logic     [12:0] ext_read_addr,
	output logic            readout_protect,
	output logic            call_push,
	output logic            ret_pop,
	output logic     [11:0] return_addr
);
	logic [7:0] window_image;
	initial begin
		{pc_addr, data_addr, data_wr, data_rd, data_wdata, ext_read_req} = '0;
		{ext_read_addr, readout_protect, call_push, ret_pop, return_addr} = '0;
	end
	// whole-byte accesses only; the window base is never bit-modified
	task automatic acc(input logic [7:0] a, input logic rd, input logic wr, input logic [7:0] wd);
		@(negedge core_clk);
		if (wr && a == 8'hc9) begin
			window_image = wd;
		end
		data_addr = a;
		data_rd = rd;
		data_wr = wr;
		data_wdata = wd;
		@(negedge core_clk);
		data_rd = 1'b0;
		data_wr = 1'b0;
		data_wdata = ~wd;
	endtask
	task automatic stk(input logic push, input logic pop, input logic [11:0] ra);
		@(negedge core_clk);
		call_push = push;
		ret_pop = pop;
		return_addr = ra;
		@(negedge core_clk);
		call_push = 1'b0;
		ret_pop = 1'b0;
	endtask
endmodule

// file: tb/pdmm_mapper_test.sv
// Purpose: self-checking bench of the memory mapper
// Assumes: core model drives all inputs except core_clk and reset_n at the falling edge
// Notes:   outputs are checked one falling edge after their cause
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
	$display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module pdmm_mapper_test;
	logic                   core_clk, reset_n, data_wr, data_rd, ext_read_req, readout_protect, call_push, ret_pop;
	logic [11:0]            pc_addr, return_addr, stack_top;
	logic [7:0]             data_addr, data_wdata;
	logic [12:0]            ext_read_addr, prog_fetch_addr, rom_window_addr, ext_mem_addr;
	logic                   rom_window_rd, ext_mem_rd, ext_read_blocked, write_only_hit;
	logic [1:0]             ram_bank_sel;
	logic [2:0]             stack_level;
	pdmm_pkg::pdmm_region_t data_region;
	int                     mismatches = 0;
	int                     total_checks = 0;
	logic [7:0]             bw [3] = '{8'h08, 8'h10, 8'h00};
	pdmm_pkg::pdmm_region_t rb [3] = '{pdmm_pkg::PDMM_REG_RAM_BANK1, pdmm_pkg::PDMM_REG_RAM_BANK2,
		pdmm_pkg::PDMM_REG_RAM_BANK0};
	logic [7:0]             da [8] = '{8'h83, 8'hbf, 8'hc3, 8'hc4, 8'hcb, 8'hcf, 8'hdc, 8'hff};
	pdmm_pkg::pdmm_region_t dr [8] = '{pdmm_pkg::PDMM_REG_POINTER, pdmm_pkg::PDMM_REG_RAM,
		pdmm_pkg::PDMM_REG_PORT_DATA, pdmm_pkg::PDMM_REG_PORT_DIR, pdmm_pkg::PDMM_REG_WRITE_ONLY,
		pdmm_pkg::PDMM_REG_PORT_OPT, pdmm_pkg::PDMM_REG_WRITE_ONLY, pdmm_pkg::PDMM_REG_ACCUM};
	pdmm_mapper     uut (.*);
	pdmm_core_model core (.*);
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#(2000 * 50);
		mismatches++;
		tally_and_finish();
	end
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		repeat (5) @(negedge core_clk);
		reset_n = 1'b1;
		core.acc(8'hc9, 1'b0, 1'b1, 8'h05);
		core.acc(8'h41, 1'b1, 1'b0, 8'h00);
		`CHK("win addr", 13'h0141, rom_window_addr)
		`CHK("win rd", 1'b1, rom_window_rd)
		`CHK("region", pdmm_pkg::PDMM_REG_ROM_WINDOW, data_region)
		core.acc(8'hc9, 1'b1, 1'b0, 8'h00);
		`CHK("win rd off", 1'b0, rom_window_rd)
		core.acc(8'h7f, 1'b1, 1'b0, 8'h00);
		`CHK("win kept", 13'h017f, rom_window_addr)
		`CHK("win image", {core.window_image[6:0], 6'h3f}, rom_window_addr)
		core.acc(8'hc9, 1'b0, 1'b1, 8'hff);
		core.acc(8'h40, 1'b1, 1'b0, 8'h00);
		`CHK("win top", 13'h1fc0, rom_window_addr)
		for (int p = 0; p < 4; p++) begin
			core.acc(8'hca, 1'b0, 1'b1, {6'h3f, 2'(p)});
			core.pc_addr = 12'h123;
			@(negedge core_clk);
			`CHK("page", {2'(p), 11'h123}, prog_fetch_addr)
			core.pc_addr = 12'h923;
			@(negedge core_clk);
			`CHK("static", {2'h1, 11'h123}, prog_fetch_addr)
		end
		core.acc(8'hca, 1'b1, 1'b0, 8'h00);
		core.pc_addr = 12'h123;
		@(negedge core_clk);
		`CHK("page kept", {2'h3, 11'h123}, prog_fetch_addr)
		for (int i = 0; i < 3; i++) begin
			core.acc(8'hcb, 1'b0, 1'b1, bw[i]);
			core.acc(8'h3f, 1'b1, 1'b0, 8'h00);
			`CHK("bank", {bw[i][4], bw[i][3]}, ram_bank_sel)
			`CHK("bank region", rb[i], data_region)
		end
		for (int i = 0; i < 8; i++) begin
			core.acc(da[i], 1'b1, 1'b0, 8'h00);
			`CHK("region", dr[i], data_region)
			`CHK("wo hit", dr[i] == pdmm_pkg::PDMM_REG_WRITE_ONLY, write_only_hit)
		end
		core.ext_read_req = 1'b1;
		core.ext_read_addr = 13'h1abc;
		for (int k = 0; k < 2; k++) begin
			core.readout_protect = 1'(k);
			@(negedge core_clk);
			`CHK("readout", {1'(k), !1'(k), 13'h1abc}, {ext_read_blocked, ext_mem_rd, ext_mem_addr})
		end
		core.ext_read_req = 1'b0;
		for (int i = 1; i < 8; i++) begin
			core.stk(1'b1, 1'b0, 12'(i));
		end
		`CHK("stack full", {3'h6, 12'h006}, {stack_level, stack_top})
		repeat (6) core.stk(1'b0, 1'b1, 12'h000);
		`CHK("stack empty", {3'h0, 12'h000}, {stack_level, stack_top})
		`CHK("page after calls", {2'h3, 11'h123}, prog_fetch_addr)
		tally_and_finish();
	end
endmodule
